// File: rcdw_pkg.sv
`default_nettype none
package rcdw_pkg;

	////////////////////////////////////////////////////////////////////////
	// volatile read configuration register layout
	localparam int VCR_W = 8;
	localparam int DUM_MSB = 7;
	localparam int DUM_LSB = 4;
	localparam int XIP_BIT = 3;
	localparam int RSV_BIT = 2;
	localparam int WRAP_MSB = 1;
	localparam int WRAP_LSB = 0;
	// dummy field 1111, xip disabled, reserved 0, sequential
	localparam logic [7:0] VCR_RST = 8'hFB;

	////////////////////////////////////////////////////////////////////////
	// nonvolatile configuration word layout
	localparam int NV_W = 16;
	localparam int NV_DUM_MSB = 15;
	localparam int NV_DUM_LSB = 12;
	localparam int NV_QUAD_BIT = 3;
	localparam int NV_DUAL_BIT = 2;

	////////////////////////////////////////////////////////////////////////
	// encodings
	localparam logic [3:0] DUM_ALT0 = 4'h0;
	localparam logic [3:0] DUM_ALT1 = 4'hF;
	// default count: ten cycles carry every fast read type at full rate
	localparam logic [3:0] DUM_DEF = 4'hA;
	localparam logic [1:0] WRAP_16 = 2'h0;
	localparam logic [1:0] WRAP_32 = 2'h1;
	localparam logic [1:0] WRAP_64 = 2'h2;
	localparam logic [1:0] WRAP_SEQ = 2'h3;
	localparam logic [5:0] MASK_16 = 6'h0F;
	localparam logic [5:0] MASK_32 = 6'h1F;
	localparam logic [5:0] MASK_64 = 6'h3F;
	localparam logic [1:0] PROTO_EXT = 2'h0;
	localparam logic [1:0] PROTO_DUAL = 2'h1;
	localparam logic [1:0] PROTO_QUAD = 2'h2;
	localparam logic [3:0] FEAT_XIP_A = 4'h2;
	localparam logic [3:0] FEAT_XIP_B = 4'h4;

	////////////////////////////////////////////////////////////////////////
	// timing: system cycles after reset release before the nv word is taken
	localparam logic [2:0] POR_CYC = 3'h4;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_DUMMY, SEQ_DATA} rcdw_seq_t;

	function automatic logic [3:0] dummy_cycles(input logic [3:0] f);
		return (f == DUM_ALT0 || f == DUM_ALT1) ? DUM_DEF : f;
	endfunction

	function automatic logic [5:0] wrap_mask(input logic [1:0] w);
		case (w)
			WRAP_16: return MASK_16;
			WRAP_32: return MASK_32;
			WRAP_64: return MASK_64;
			default: return 6'h00;
		endcase
	endfunction

endpackage
`default_nettype wire

// File: rcdw_top.sv
// Function
// [RULE1] dummy cycles from volatile bits 7:4 precede data
// [RULE2] codes 0000 and 1111 both mean default count
// [RULE3] host picks dummy count suiting its clock
// [RULE4] active-low nv bits select dual or quad
// [RULE5] volatile bit 3 gates xip, forced on some variants
// [RULE6] wrap bits pick 16/32/64-byte or sequential
// [RULE7] wrap reads circle within the aligned block
// [RULE8] write-command completion applies new volatile value
// [RULE9] single rate: ten dummies allow 108 MHz
// [RULE10] double rate: ten dummies allow 54 MHz
// [RULE11] nv bits 15:12 give power-on dummy count
// [RULE12] reset loads default dummy and sequential wrap
`timescale 1ns/1ps
`default_nettype none
module rcdw_top #(
	parameter logic [3:0] FEATURE_DIGIT = 4'h1,
	parameter int ADDR_W = 32
) (
	// system side
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [15:0] i_nv_cfg,
	output logic [1:0] o_proto,
	output logic o_xip_en,
	output logic [1:0] o_wrap_mode,
	output logic [3:0] o_dummy_cyc,
	output logic [7:0] o_vcr_sys,
	output logic o_cfg_ready,
	// link side, on the serial clock
	input wire logic i_lnk_clk,
	input wire logic i_lnk_cs_n,
	input wire logic i_lnk_wr_vcr,
	input wire logic [7:0] i_lnk_wr_data,
	input wire logic i_lnk_rd_start,
	input wire logic [ADDR_W-1:0] i_lnk_rd_addr,
	input wire logic i_lnk_byte_done,
	output logic [7:0] o_lnk_vcr,
	output logic o_lnk_out_en,
	output logic [ADDR_W-1:0] o_lnk_rd_addr
);

	localparam logic XIP_FORCED = (FEATURE_DIGIT == rcdw_pkg::FEAT_XIP_A) ||
		(FEATURE_DIGIT == rcdw_pkg::FEAT_XIP_B);

	////////////////////////////////////////////////////////////////////////
	// system domain: power-on capture of the nv word, view of the register
	logic [15:0] nv_s1_r;
	logic [15:0] nv_s2_r;
	logic lv_s1_r;
	logic lv_s2_r;
	logic lv_s3_r;
	logic [2:0] por_cnt_r;
	logic [2:0] por_cnt_nxt;
	logic cfg_ready_nxt;
	logic [1:0] proto_nxt;
	logic [3:0] nv_dum_r;
	logic [3:0] nv_dum_nxt;
	logic sys_tgl_r;
	logic sys_tgl_nxt;
	logic [7:0] vcr_sys_nxt;
	logic lnk_tgl_r;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			nv_s1_r <= 16'hFFFF;
			nv_s2_r <= 16'hFFFF;
			lv_s1_r <= 1'b0;
			lv_s2_r <= 1'b0;
			lv_s3_r <= 1'b0;
		end else begin
			nv_s1_r <= i_nv_cfg;
			nv_s2_r <= nv_s1_r;
			lv_s1_r <= lnk_tgl_r;
			lv_s2_r <= lv_s1_r;
			lv_s3_r <= lv_s2_r;
		end
	end

	always_comb begin
		por_cnt_nxt = por_cnt_r;
		cfg_ready_nxt = o_cfg_ready;
		proto_nxt = o_proto;
		nv_dum_nxt = nv_dum_r;
		sys_tgl_nxt = sys_tgl_r;
		vcr_sys_nxt = o_vcr_sys;
		if (!o_cfg_ready) begin
			if (por_cnt_r == rcdw_pkg::POR_CYC) begin
				// protocol is fixed until the next power-on
				cfg_ready_nxt = 1'b1;
				if (!nv_s2_r[rcdw_pkg::NV_QUAD_BIT])
					proto_nxt = rcdw_pkg::PROTO_QUAD; // [RULE4]
				else if (!nv_s2_r[rcdw_pkg::NV_DUAL_BIT])
					proto_nxt = rcdw_pkg::PROTO_DUAL; // [RULE4]
				else
					proto_nxt = rcdw_pkg::PROTO_EXT;
				nv_dum_nxt = nv_s2_r[rcdw_pkg::NV_DUM_MSB:rcdw_pkg::NV_DUM_LSB];
				sys_tgl_nxt = ~sys_tgl_r; // [RULE11]
			end else begin
				por_cnt_nxt = por_cnt_r + 3'h1;
			end
		end
		// link word is stable while its toggle crosses
		if (lv_s2_r ^ lv_s3_r)
			vcr_sys_nxt = o_lnk_vcr;
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			por_cnt_r <= 3'h0;
			o_cfg_ready <= 1'b0;
			o_proto <= rcdw_pkg::PROTO_EXT;
			nv_dum_r <= rcdw_pkg::DUM_ALT1;
			sys_tgl_r <= 1'b0;
			o_vcr_sys <= rcdw_pkg::VCR_RST;
			o_xip_en <= XIP_FORCED;
			o_wrap_mode <= rcdw_pkg::WRAP_SEQ;
			o_dummy_cyc <= rcdw_pkg::DUM_DEF;
		end else begin
			por_cnt_r <= por_cnt_nxt;
			o_cfg_ready <= cfg_ready_nxt;
			o_proto <= proto_nxt;
			nv_dum_r <= nv_dum_nxt;
			sys_tgl_r <= sys_tgl_nxt;
			o_vcr_sys <= vcr_sys_nxt;
			// bit low enables xip unless the variant forces it
			o_xip_en <= XIP_FORCED | ~vcr_sys_nxt[rcdw_pkg::XIP_BIT]; // [RULE5]
			o_wrap_mode <= vcr_sys_nxt[rcdw_pkg::WRAP_MSB:rcdw_pkg::WRAP_LSB];
			o_dummy_cyc <= rcdw_pkg::dummy_cycles(
				vcr_sys_nxt[rcdw_pkg::DUM_MSB:rcdw_pkg::DUM_LSB]); // [RULE2]
		end
	end

	a_proto_quad: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$rose(o_cfg_ready) && !$past(nv_s2_r[rcdw_pkg::NV_QUAD_BIT])
		|-> o_proto == rcdw_pkg::PROTO_QUAD) // [RULE4]
		else $error("quad bit low but quad not selected");

	a_proto_dual: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$rose(o_cfg_ready) && $past(nv_s2_r[rcdw_pkg::NV_QUAD_BIT]) &&
		!$past(nv_s2_r[rcdw_pkg::NV_DUAL_BIT])
		|-> o_proto == rcdw_pkg::PROTO_DUAL) // [RULE4]
		else $error("dual bit low but dual not selected");

	a_proto_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_cfg_ready |=> $stable(o_proto) && o_cfg_ready) // [RULE4]
		else $error("protocol changed after power-on capture");

	a_xip_forced: assert property (@(posedge i_clk) disable iff (!i_rstn)
		XIP_FORCED |-> o_xip_en) // [RULE5]
		else $error("forced xip variant left xip off");

	////////////////////////////////////////////////////////////////////////
	// link domain: the register itself, written by its command and by the power-on dummy load
	logic ns_s1_r;
	logic ns_s2_r;
	logic ns_s3_r;
	logic [7:0] lnk_vcr_nxt;
	logic lnk_tgl_nxt;

	always_ff @(posedge i_lnk_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ns_s1_r <= 1'b0;
			ns_s2_r <= 1'b0;
			ns_s3_r <= 1'b0;
		end else begin
			ns_s1_r <= sys_tgl_r;
			ns_s2_r <= ns_s1_r;
			ns_s3_r <= ns_s2_r;
		end
	end

	always_comb begin
		lnk_vcr_nxt = o_lnk_vcr;
		lnk_tgl_nxt = lnk_tgl_r;
		if (i_lnk_wr_vcr) begin
			// a host write beats a late power-on dummy load
			lnk_vcr_nxt = {i_lnk_wr_data[7:3], 1'b0, i_lnk_wr_data[1:0]}; // [RULE8]
			lnk_tgl_nxt = ~lnk_tgl_r;
		end else if (ns_s2_r ^ ns_s3_r) begin
			lnk_vcr_nxt[rcdw_pkg::DUM_MSB:rcdw_pkg::DUM_LSB] = nv_dum_r; // [RULE11]
			lnk_tgl_nxt = ~lnk_tgl_r;
		end
	end

	always_ff @(posedge i_lnk_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_lnk_vcr <= rcdw_pkg::VCR_RST; // [RULE12]
			lnk_tgl_r <= 1'b0;
		end else begin
			o_lnk_vcr <= lnk_vcr_nxt;
			lnk_tgl_r <= lnk_tgl_nxt;
		end
	end

	a_vcr_write: assert property (@(posedge i_lnk_clk) disable iff (!i_rstn)
		i_lnk_wr_vcr |=> o_lnk_vcr == {$past(i_lnk_wr_data[7:3]), 1'b0,
		$past(i_lnk_wr_data[1:0])}) // [RULE8]
		else $error("volatile write not applied at completion");

	a_vcr_quiet: assert property (@(posedge i_lnk_clk) disable iff (!i_rstn)
		!i_lnk_wr_vcr && !(ns_s2_r ^ ns_s3_r) |=> $stable(o_lnk_vcr)) // [RULE8]
		else $error("volatile register changed without a write");

	a_nv_dummy: assert property (@(posedge i_lnk_clk) disable iff (!i_rstn)
		(ns_s2_r ^ ns_s3_r) && !i_lnk_wr_vcr
		|=> o_lnk_vcr[rcdw_pkg::DUM_MSB:rcdw_pkg::DUM_LSB] == nv_dum_r) // [RULE11]
		else $error("power-on dummy count not loaded");

	////////////////////////////////////////////////////////////////////////
	// link domain: read sequencer; chip select ends the frame even if
	// the serial clock stops right after the last byte
	logic seq_rst_n;
	rcdw_pkg::rcdw_seq_t seq_r;
	rcdw_pkg::rcdw_seq_t seq_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic out_en_nxt;
	logic [ADDR_W-1:0] rd_addr_nxt;
	logic [ADDR_W-1:0] addr_inc;
	logic [ADDR_W-1:0] wmask;
	logic [1:0] wrap_sel;

	assign seq_rst_n = i_rstn & ~i_lnk_cs_n;
	assign wrap_sel = o_lnk_vcr[rcdw_pkg::WRAP_MSB:rcdw_pkg::WRAP_LSB];
	assign addr_inc = o_lnk_rd_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
	assign wmask = {{(ADDR_W-6){1'b0}}, rcdw_pkg::wrap_mask(wrap_sel)};

	always_comb begin
		seq_nxt = seq_r;
		cnt_nxt = cnt_r;
		out_en_nxt = o_lnk_out_en;
		rd_addr_nxt = o_lnk_rd_addr;
		if (i_lnk_rd_start) begin
			seq_nxt = rcdw_pkg::SEQ_DUMMY;
			cnt_nxt = rcdw_pkg::dummy_cycles(
				o_lnk_vcr[rcdw_pkg::DUM_MSB:rcdw_pkg::DUM_LSB]); // [RULE1] [RULE2]
			out_en_nxt = 1'b0;
			rd_addr_nxt = i_lnk_rd_addr;
		end else begin
			case (seq_r)
				rcdw_pkg::SEQ_DUMMY: begin
					if (cnt_r <= 4'h1) begin
						seq_nxt = rcdw_pkg::SEQ_DATA;
						out_en_nxt = 1'b1; // [RULE1]
					end else begin
						cnt_nxt = cnt_r - 4'h1;
					end
				end
				rcdw_pkg::SEQ_DATA: begin
					if (i_lnk_byte_done) begin
						if (wrap_sel == rcdw_pkg::WRAP_SEQ)
							rd_addr_nxt = addr_inc; // [RULE6]
						else
							rd_addr_nxt = (o_lnk_rd_addr & ~wmask) |
								(addr_inc & wmask); // [RULE7]
					end
				end
				default: begin
					seq_nxt = rcdw_pkg::SEQ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_lnk_clk or negedge seq_rst_n) begin
		if (!seq_rst_n) begin
			seq_r <= rcdw_pkg::SEQ_IDLE;
			cnt_r <= 4'h0;
			o_lnk_out_en <= 1'b0;
			o_lnk_rd_addr <= {ADDR_W{1'b0}};
		end else begin
			seq_r <= seq_nxt;
			cnt_r <= cnt_nxt;
			o_lnk_out_en <= out_en_nxt;
			o_lnk_rd_addr <= rd_addr_nxt;
		end
	end

	a_dummy_load: assert property (@(posedge i_lnk_clk) disable iff (!seq_rst_n)
		i_lnk_rd_start |=> seq_r == rcdw_pkg::SEQ_DUMMY && !o_lnk_out_en &&
		cnt_r == rcdw_pkg::dummy_cycles(
		$past(o_lnk_vcr[rcdw_pkg::DUM_MSB:rcdw_pkg::DUM_LSB]))) // [RULE1]
		else $error("dummy phase not started with programmed count");

	a_dummy_alias: assert property (@(posedge i_lnk_clk) disable iff (!seq_rst_n)
		i_lnk_rd_start && (o_lnk_vcr[7:4] == rcdw_pkg::DUM_ALT0 ||
		o_lnk_vcr[7:4] == rcdw_pkg::DUM_ALT1)
		|=> cnt_r == rcdw_pkg::DUM_DEF) // [RULE2]
		else $error("code 0000 or 1111 did not give default count");

	a_dummy_exit: assert property (@(posedge i_lnk_clk) disable iff (!seq_rst_n)
		seq_r == rcdw_pkg::SEQ_DUMMY && cnt_r == 4'h2 && !i_lnk_rd_start
		##1 !i_lnk_rd_start |=> o_lnk_out_en && seq_r == rcdw_pkg::SEQ_DATA)
		// [RULE1]
		else $error("data did not follow the last dummy cycle");

	a_no_early: assert property (@(posedge i_lnk_clk) disable iff (!seq_rst_n)
		seq_r != rcdw_pkg::SEQ_DATA |-> !o_lnk_out_en) // [RULE1]
		else $error("output enabled before dummy cycles ended");

	a_seq_incr: assert property (@(posedge i_lnk_clk) disable iff (!seq_rst_n)
		seq_r == rcdw_pkg::SEQ_DATA && i_lnk_byte_done && !i_lnk_rd_start &&
		wrap_sel == rcdw_pkg::WRAP_SEQ
		|=> o_lnk_rd_addr == $past(addr_inc)) // [RULE6]
		else $error("sequential read did not advance by one");

	a_wrap_stay: assert property (@(posedge i_lnk_clk) disable iff (!seq_rst_n)
		seq_r == rcdw_pkg::SEQ_DATA && i_lnk_byte_done && !i_lnk_rd_start &&
		wrap_sel != rcdw_pkg::WRAP_SEQ
		|=> o_lnk_rd_addr[ADDR_W-1:6] == $past(o_lnk_rd_addr[ADDR_W-1:6]))
		// [RULE7]
		else $error("wrap read left its aligned block");

	a_wrap_16: assert property (@(posedge i_lnk_clk) disable iff (!seq_rst_n)
		seq_r == rcdw_pkg::SEQ_DATA && i_lnk_byte_done && !i_lnk_rd_start &&
		wrap_sel == rcdw_pkg::WRAP_16 && o_lnk_rd_addr[3:0] == 4'hF
		|=> o_lnk_rd_addr[3:0] == 4'h0 &&
		o_lnk_rd_addr[ADDR_W-1:4] == $past(o_lnk_rd_addr[ADDR_W-1:4]))
		// [RULE6] [RULE7]
		else $error("16-byte wrap did not return to block start");

endmodule // rcdw_top
`default_nettype wire

// File: rcdw_host.sv
`timescale 1ns/1ps
`default_nettype none
module rcdw_host #(
	parameter int ADDR_W = 32,
	// serial rate the host claims for its reads, and whether both edges
	parameter int RATE_MHZ = 90,
	parameter bit DTR = 1'b0
) (
	// link requests
	output logic o_lnk_clk,
	output logic o_cs_n,
	output logic o_wr,
	output logic [7:0] o_wdat,
	output logic o_rd,
	output logic [ADDR_W-1:0] o_addr,
	output logic o_bdone,
	// device answers
	input wire logic i_out_en,
	input wire logic [ADDR_W-1:0] i_cur
);
	logic run;
	int rate_err;
	// plain fast read limit per dummy count; double rate halves it
	function automatic int max_mhz(input int n, input bit dtr);
		int f;
		f = (n >= 3) ? 108 : (n == 2) ? 100 : 90;
		return dtr ? f / 2 : f;
	endfunction
	initial begin
		run = 1'h0;
		rate_err = 0;
		o_lnk_clk = 1'h0;
		o_cs_n = 1'h1;
		o_wr = 1'h0;
		o_wdat = 8'h00;
		o_rd = 1'h0;
		o_addr = '0;
		o_bdone = 1'h0;
	end
	// serial clock stands still between frames
	always #3 o_lnk_clk = run ? ~o_lnk_clk : 1'h0;
	////////////////////////////////////////////////////////////////////
	task automatic open_f();
		o_cs_n = 1'h0;
		run = 1'h1;
		@(posedge o_lnk_clk);
		#1;
	endtask
	task automatic close_f();
		@(posedge o_lnk_clk);
		#1;
		run = 1'h0;
		o_cs_n = 1'h1;
		// deselect gap, so a following frame never reopens in this step
		#12;
	endtask
	task automatic idle(input int n);
		open_f();
		repeat (n) @(posedge o_lnk_clk);
		close_f();
	endtask
	task automatic write(input logic [7:0] d);
		open_f();
		o_wr = 1'h1;
		o_wdat = d;
		@(posedge o_lnk_clk);
		#1;
		o_wr = 1'h0;
		// released data must not keep showing the last value
		o_wdat = ~d;
		close_f();
	endtask
	task automatic read(input logic [ADDR_W-1:0] a, input int nd,
		input int nb, output int lat, output logic [ADDR_W-1:0] seq [0:7]);
		lat = 0;
		// a count too short for the claimed rate returns bad data
		if (RATE_MHZ > max_mhz(nd, DTR))
			rate_err++;
		open_f();
		o_rd = 1'h1;
		o_addr = a;
		@(posedge o_lnk_clk);
		#1;
		o_rd = 1'h0;
		o_addr = ~a;
		while (i_out_en !== 1'h1 && lat < 20) begin
			@(posedge o_lnk_clk);
			#1;
			lat++;
		end
		seq[0] = i_cur;
		o_bdone = 1'h1;
		for (int i = 1; i < nb; i++) begin
			@(posedge o_lnk_clk);
			#1;
			seq[i] = i_cur;
		end
		o_bdone = 1'h0;
		close_f();
	endtask
endmodule // rcdw_host
`default_nettype wire

// File: read_config_dummy_wrap_tb.sv
`timescale 1ns/1ps
`default_nettype none
module read_config_dummy_wrap_tb;
	typedef struct {logic [7:0] wd, vcr; logic [3:0] dum;
		logic [1:0] wrap; logic xip; logic [31:0] addr;} rcdw_row_t;
	logic i_clk, i_rstn;
	logic [15:0] i_nv_cfg;
	logic [1:0] proto, wrap;
	logic xip, xip2, rdy, out_en, lclk, cs_n, wr, rd, bdone;
	logic [3:0] dum;
	logic [7:0] vsys, lvcr, wdat;
	logic [31:0] raddr, cur, ea;
	logic [31:0] seq [0:7];
	int error_cnt = 0;
	int checks = 0;
	int lat;
	rcdw_row_t rows [0:4];
	rcdw_top u_dut (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_nv_cfg(i_nv_cfg),
		.o_proto(proto), .o_xip_en(xip), .o_wrap_mode(wrap),
		.o_dummy_cyc(dum), .o_vcr_sys(vsys), .o_cfg_ready(rdy),
		.i_lnk_clk(lclk), .i_lnk_cs_n(cs_n), .i_lnk_wr_vcr(wr),
		.i_lnk_wr_data(wdat), .i_lnk_rd_start(rd), .i_lnk_rd_addr(raddr),
		.i_lnk_byte_done(bdone), .o_lnk_vcr(lvcr), .o_lnk_out_en(out_en),
		.o_lnk_rd_addr(cur)
	);
	// variant whose xip bit is ignored
	rcdw_top #(.FEATURE_DIGIT(4'h2)) u_dut_xip (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_nv_cfg(i_nv_cfg),
		.o_proto(), .o_xip_en(xip2), .o_wrap_mode(), .o_dummy_cyc(),
		.o_vcr_sys(), .o_cfg_ready(), .i_lnk_clk(lclk), .i_lnk_cs_n(cs_n),
		.i_lnk_wr_vcr(wr), .i_lnk_wr_data(wdat), .i_lnk_rd_start(rd),
		.i_lnk_rd_addr(raddr), .i_lnk_byte_done(bdone), .o_lnk_vcr(),
		.o_lnk_out_en(), .o_lnk_rd_addr()
	);
	rcdw_host u_host (
		.o_lnk_clk(lclk), .o_cs_n(cs_n), .o_wr(wr), .o_wdat(wdat),
		.o_rd(rd), .o_addr(raddr), .o_bdone(bdone), .i_out_en(out_en),
		.i_cur(cur)
	);
	initial i_clk = 1'h0;
	always #12.5 i_clk = ~i_clk;
	////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	function automatic logic [31:0] nxt(input logic [31:0] a,
		input logic [1:0] w);
		logic [31:0] m;
		m = (w == 2'h0) ? 32'hF : (w == 2'h1) ? 32'h1F : 32'h3F;
		return (w == 2'h3) ? a + 32'h1 : (a & ~m) | ((a + 32'h1) & m);
	endfunction
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// link clock must run after reset release so the nv load reaches the register
	task automatic do_reset(input logic [15:0] nv);
		@(negedge i_clk);
		i_rstn = 1'h0;
		i_nv_cfg = nv;
		repeat (18) @(negedge i_clk);
		u_host.idle(4);
		@(negedge i_clk);
		check("lnk_vcr", lvcr, 8'hFB);
		check("vcr_sys", vsys, 8'hFB);
		check("wrap", wrap, 2'h3);
		check("dummy_cyc", dum, 4'hA);
		check("ready", rdy, 1'h0);
		i_rstn = 1'h1;
		repeat (10) @(negedge i_clk);
		u_host.idle(12);
		repeat (8) @(negedge i_clk);
	endtask
	task automatic nv_case(input logic [15:0] nv, input logic [1:0] ep,
		input logic [3:0] ed);
		do_reset(nv);
		check("ready", rdy, 1'h1);
		check("proto", proto, ep);
		check("nv_dummy", lvcr[7:4], nv[15:12]);
		check("dummy_cyc", dum, ed);
		u_host.read(32'h40, ed, 2, lat, seq);
		check("latency", lat, ed);
		$display("nv case %h done", nv);
	endtask
	initial begin
		#400000;
		error_cnt++;
		$display("[FAIL] watchdog expected end seen hang");
		end_sim();
	end
	initial begin
		i_rstn = 1'h0;
		i_nv_cfg = 16'hFFFF;
		rows[0] = '{8'h00, 8'h00, 4'hA, 2'h0, 1'h1, 32'h0000000F};
		rows[1] = '{8'hF7, 8'hF3, 4'hA, 2'h3, 1'h1, 32'h000000FF};
		rows[2] = '{8'h5D, 8'h59, 4'h5, 2'h1, 1'h0, 32'h0000003E};
		rows[3] = '{8'hEA, 8'hEA, 4'hE, 2'h2, 1'h0, 32'h0000007D};
		rows[4] = '{8'h1C, 8'h18, 4'h1, 2'h0, 1'h0, 32'h0000002E};
		do_reset(16'hFFFF);
		foreach (rows[k]) begin
			u_host.write(rows[k].wd);
			u_host.idle(6);
			repeat (8) @(negedge i_clk);
			check("lnk_vcr", lvcr, rows[k].vcr);
			check("vcr_sys", vsys, rows[k].vcr);
			check("dummy_cyc", dum, rows[k].dum);
			check("wrap", wrap, rows[k].wrap);
			check("xip", xip, rows[k].xip);
			check("xip_forced", xip2, 1'h1);
			u_host.read(rows[k].addr, rows[k].dum, 8, lat, seq);
			check("latency", lat, rows[k].dum);
			ea = rows[k].addr;
			for (int i = 0; i < 8; i++) begin
				check("rd_addr", seq[i], ea);
				ea = nxt(ea, rows[k].wrap);
			end
			@(negedge i_clk);
			check("out_en_idle", out_en, 1'h0);
			$display("row %0d done", k);
		end
		nv_case(16'hFFF7, rcdw_pkg::PROTO_QUAD, 4'hA);
		nv_case(16'hFFFB, rcdw_pkg::PROTO_DUAL, 4'hA);
		nv_case(16'h3FF3, rcdw_pkg::PROTO_QUAD, 4'h3);
		nv_case(16'h0FFF, rcdw_pkg::PROTO_EXT, 4'hA);
		check("host_rate", u_host.rate_err, 32'h0);
		end_sim();
	end
endmodule // read_config_dummy_wrap_tb
`default_nettype wire
